// [sim/fbp_pins.sv]
// Pin model: a driven pin shows its drive, a pulled-up pin reads high.
module fbp_pins (
	input wire logic [3:0] pin_out,
	input wire logic [3:0] pin_oe,
	input wire logic [3:0] pin_pullup,
	input wire logic [3:0] ext,
	output logic [3:0] pin_in
);
	timeunit 1ns;
	timeprecision 1ps;
	assign pin_in = pin_oe & pin_out | ~pin_oe & (pin_pullup | ext);
endmodule // fbp_pins

// [sim/fbp_port_properties.sv]
// Checker for the port's pins, readback and reset request.
module fbp_port_chk (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic hf_osc_enable,
	input wire logic sysclk_reset,
	input fbp_pkg::fbp_req_t req,
	input wire logic [7:0] rdata,
	input wire logic [3:0] pin_in,
	input wire logic [3:0] pin_out,
	input wire logic [3:0] pin_oe,
	input wire logic [3:0] pin_pullup
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	wire [11:0] a = req.addr;
	wire [3:0] d = req.wdata[3:0];
	wire w = req.wr, r = req.rd && a == 12'h00d;
	logic [1:0] s_q;
	// Shadow of the two select bits, so readback gating can be judged.
	always_ff @(posedge ref_clk) s_q <= rst ? 2'h1 :
		w && a == 12'hf34 ? {d[2], d[0]} : s_q;
	property p_o; w && a == 12'h000 |=> pin_out == $past(d); endproperty
	a_o: assert property (p_o) else $error("bad drive");
	property p_d; w && a == 12'hf1a |=> pin_oe == $past(d); endproperty
	a_d: assert property (p_d) else $error("bad dir");
	property p_r; w && a == 12'hf34 && !d[0] && hf_osc_enable |=>
		sysclk_reset; endproperty
	a_r: assert property (p_r) else $error("no reset");
	property p_u; (pin_pullup & pin_oe) == 4'h0; endproperty
	a_u: assert property (p_u) else $error("bad pullup");
	property p_b; r |=>
		(rdata[3:0] & ($past(pin_oe) | ~$past(pin_in))) == 4'h0;
	endproperty
	a_b: assert property (p_b) else $error("bad readback");
	property p_h; r && s_q[0] |=> rdata[1:0] == 2'h0; endproperty
	a_h: assert property (p_h) else $error("fast pins");
	property p_l; r && s_q[1] |=> rdata[3:2] == 2'h0; endproperty
	a_l: assert property (p_l) else $error("slow pins");
	property p_t; req.rd |=> rdata[7:4] == 4'h0; endproperty
	a_t: assert property (p_t) else $error("upper bits");
	cover property (sysclk_reset);
	cover property (r && !s_q[0]);
	cover property (w && a == 12'hf1a);
endmodule // fbp_port_chk
bind fbp_port fbp_port_chk i_fbp_port_chk (
	.ref_clk(ref_clk),
	.rst(rst),
	.hf_osc_enable(hf_osc_enable),
	.sysclk_reset(sysclk_reset),
	.req(req),
	.rdata(rdata),
	.pin_in(pin_in),
	.pin_out(pin_out),
	.pin_oe(pin_oe),
	.pin_pullup(pin_pullup)
);

// [sim/fbp_port_tb.sv]
// Self-checking bench for the four-bit port.
module fbp_port_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic ref_clk = 0, rst = 1, hf = 0, sr;
	logic [3:0] po, oe, pu, pi;
	logic [7:0] rdata;
	fbp_pkg::fbp_req_t req = '0;
	int err_count = 0, n_compared = 0;
	always #2.5 ref_clk = ~ref_clk;
	fbp_port i_fbp_port (.ref_clk, .rst, .req, .rdata, .hf_osc_enable(hf),
		.pin_in(pi), .pin_out(po), .pin_oe(oe), .pin_pullup(pu),
		.sysclk_reset(sr));
	fbp_pins i_fbp_pins (.pin_out(po), .pin_oe(oe), .pin_pullup(pu),
		.ext(4'h0), .pin_in(pi));
	task ck(string n, logic [7:0] e, logic [7:0] s);
		n_compared++;
		if (s !== e) begin
			err_count++;
			$display("MISMATCH %s exp %h got %h", n, e, s);
		end
	endtask
	task wr(logic [11:0] a, logic [7:0] v);
		@(posedge ref_clk) req <= '{a, v, 1'b1, 1'b0};
		@(posedge ref_clk) req.wr <= 1'b0;
		#1;
	endtask
	task rd(logic [11:0] a, logic [7:0] e);
		@(posedge ref_clk) req <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge ref_clk) req.rd <= 1'b0;
		#1 ck("rdata", e, rdata);
	endtask
	task results;
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	initial begin
		repeat (5) @(posedge ref_clk);
		rst <= 1'b0;
		rd(12'hf34, 8'h01);
		rd(12'h123, 8'h00);
		wr(12'h000, 8'hff);
		wr(12'hf1a, 8'hfc);
		ck("pin_out", 8'h0f, {4'h0, po});
		ck("pin_oe", 8'h0c, {4'h0, oe});
		wr(12'hf27, 8'hff);
		ck("pin_pullup", 8'h03, {4'h0, pu});
		rd(12'h000, 8'h0f);
		wr(12'hf34, 8'h00);
		rd(12'h00d, 8'h03);
		wr(12'hf1a, 8'h00);
		rd(12'h00d, 8'h0f);
		wr(12'hf34, 8'h04);
		rd(12'h00d, 8'h03);
		wr(12'hf34, 8'hfb);
		rd(12'hf34, 8'h01);
		rd(12'h00d, 8'h0c);
		$display("pin test done");
		@(posedge ref_clk) hf <= 1'b1;
		wr(12'hf34, 8'h00);
		ck("sysclk_reset", 8'h01, {7'h00, sr});
		wr(12'hf34, 8'h01);
		ck("sysclk_reset", 8'h00, {7'h00, sr});
		$display("reset request test done");
		results();
	end
endmodule // fbp_port_tb

// [verilog/fbp_pin_ctrl.sv]
// Per-pin drive, pull-up and readback gating for the four port pins.
module fbp_pin_ctrl (
	input wire logic [3:0] latch,
	input wire logic [3:0] dir,
	input wire logic [3:0] pu_en,
	input wire logic [3:0] osc_func,
	input wire logic [3:0] pin_in,
	output fbp_pkg::fbp_pad_t pad,
	output logic [3:0] readback
);
	logic [3:0] osc_owned;

	always_comb begin
		osc_owned = ({4{osc_func[fbp_pkg::HF_SEL_BIT]}} & fbp_pkg::HF_PIN_MASK)
			| ({4{osc_func[fbp_pkg::LF_SEL_BIT]}} & fbp_pkg::LF_PIN_MASK);
		pad.out_val = latch;
		pad.out_en = dir;
		pad.pullup_en = pu_en & ~dir;
		readback = pin_in & ~dir & ~osc_owned;
	end
endmodule // fbp_pin_ctrl

// [verilog/fbp_pkg.sv]
// Package with register map, field positions and reset values of the port.
package fbp_pkg;
	localparam logic [11:0] ADDR_OUT_LATCH = 12'h000;
	localparam logic [11:0] ADDR_IN_READBACK = 12'h00d;
	localparam logic [11:0] ADDR_DIR_CTRL = 12'hf1a;
	localparam logic [11:0] ADDR_PULLUP_EN = 12'hf27;
	localparam logic [11:0] ADDR_OSC_FUNC = 12'hf34;
	localparam logic [3:0] RST_OUT_LATCH = 4'h0;
	localparam logic [3:0] RST_DIR_CTRL = 4'h0;
	localparam logic [3:0] RST_PULLUP_EN = 4'h0;
	localparam logic [3:0] RST_OSC_FUNC = 4'h1;
	localparam int HF_SEL_BIT = 0;
	localparam int LF_SEL_BIT = 2;
	localparam logic [3:0] OSC_FUNC_WMASK = 4'h5;
	localparam logic [3:0] HF_PIN_MASK = 4'h3;
	localparam logic [3:0] LF_PIN_MASK = 4'hc;

	typedef struct packed {
		logic [11:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} fbp_req_t;

	typedef struct packed {
		logic [3:0] out_val;
		logic [3:0] out_en;
		logic [3:0] pullup_en;
	} fbp_pad_t;
endpackage

// [verilog/fbp_port.sv]
// Four-bit port with oscillator pin sharing and its register file.
//
// Implementation choice: the address-and-strobe port.
module fbp_port (
	input wire logic ref_clk,
	input wire logic rst,
	input fbp_pkg::fbp_req_t req,
	output logic [7:0] rdata,
	input wire logic hf_osc_enable,
	input wire logic [3:0] pin_in,
	output logic [3:0] pin_out,
	output logic [3:0] pin_oe,
	output logic [3:0] pin_pullup,
	output logic sysclk_reset
);

	// Register images keep only the low nibble; upper bits are not stored.
	logic [3:0] latch_q;
	logic [3:0] dir_q;
	logic [3:0] pullup_q;
	logic [3:0] osc_q;
	// Pin levels after mode and oscillator gating.
	logic [3:0] readback;
	// Image of the addressed register before the read strobe gates it.
	logic [7:0] rimage;
	logic [7:0] rdata_q;
	logic [7:0] rdata_d;
	logic sysclk_reset_q;
	// Pad controls as the pin module computes them.
	fbp_pkg::fbp_pad_t pad;

	// One select per mapped address; sel_none marks a hole in the map.
	logic sel_latch;
	logic sel_readback;
	logic sel_dir;
	logic sel_pullup;
	logic sel_osc;
	logic sel_none;

	// Write enables of the four writable registers.
	logic we_latch;
	logic we_dir;
	logic we_pullup;
	logic we_osc;

	// Write data as they land in the register images.
	logic [3:0] wnib;
	logic [3:0] wnib_osc;

	// Set when software deselects the fast oscillator pins while it runs.
	logic hf_drop;

	// Address compare and nibble conversions serve every register alike.
	function automatic logic addr_is(
		input logic [11:0] a,
		input logic [11:0] reg_addr
	);
		addr_is = (a == reg_addr);
	endfunction

	// Write data bits 7 to 4 are dropped here.
	function automatic logic [3:0] low_nibble(
		input logic [7:0] v
	);
		low_nibble = v[3:0];
	endfunction

	// Upper bits of every register read as 0.
	function automatic logic [7:0] as_byte(
		input logic [3:0] v
	);
		as_byte = {4'h0, v};
	endfunction

	// Only an exact address match selects a register; nothing is
	// mirrored, so software cannot reach a register through an alias.
	always_comb begin
		sel_latch = addr_is(req.addr, fbp_pkg::ADDR_OUT_LATCH);
		sel_readback = addr_is(req.addr, fbp_pkg::ADDR_IN_READBACK);
		sel_dir = addr_is(req.addr, fbp_pkg::ADDR_DIR_CTRL);
		sel_pullup = addr_is(req.addr, fbp_pkg::ADDR_PULLUP_EN);
		sel_osc = addr_is(req.addr, fbp_pkg::ADDR_OSC_FUNC);
		sel_none = !(sel_latch || sel_readback || sel_dir
			|| sel_pullup || sel_osc);
	end

	// The readback address has no write enable: writes there are lost.
	always_comb begin
		we_latch = req.wr && sel_latch;
		we_dir = req.wr && sel_dir;
		we_pullup = req.wr && sel_pullup;
		we_osc = req.wr && sel_osc;
	end

	// Bits 1 and 3 of the oscillator function register are held at 0.
	always_comb begin
		wnib = low_nibble(req.wdata);
		wnib_osc = low_nibble(req.wdata) & fbp_pkg::OSC_FUNC_WMASK;
	end

	// A latch write also lands while the pin is an input, so the pin
	// drives the new level the moment it is turned to output.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			latch_q <= fbp_pkg::RST_OUT_LATCH;
		end else if (we_latch) begin
			latch_q <= wnib;
		end
	end

	// Oscillator pins may be set to output; software is trusted to avoid
	// it, as the bus has no way to refuse a write.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			dir_q <= fbp_pkg::RST_DIR_CTRL;
		end else if (we_dir) begin
			dir_q <= wnib;
		end
	end

	// Enables of output pins are stored but stay inert until input mode.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			pullup_q <= fbp_pkg::RST_PULLUP_EN;
		end else if (we_pullup) begin
			pullup_q <= wnib;
		end
	end

	// The fast select leaves reset at 1, so its pins start owned.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			osc_q <= fbp_pkg::RST_OSC_FUNC;
		end else if (we_osc) begin
			osc_q <= wnib_osc;
		end
	end

	// Any such write counts, even one that leaves the select at 0, so a
	// repeated write cannot slip past the request.
	always_comb begin
		hf_drop = we_osc && hf_osc_enable
			&& !req.wdata[fbp_pkg::HF_SEL_BIT];
	end

	// The reset request is a one-cycle pulse after the offending write.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			sysclk_reset_q <= 1'h0;
		end else begin
			sysclk_reset_q <= hf_drop;
		end
	end

	// Pin gating and the pad drive sit in their own module.
	fbp_pin_ctrl i_fbp_pin_ctrl (
		.latch(latch_q),
		.dir(dir_q),
		.pu_en(pullup_q),
		.osc_func(osc_q),
		.pin_in(pin_in),
		.pad(pad),
		.readback(readback)
	);

	// Unmapped addresses fall to the default and read 0.
	always_comb begin
		rimage = 8'h00;
		case (req.addr)
			fbp_pkg::ADDR_OUT_LATCH: begin
				rimage = as_byte(latch_q);
			end
			fbp_pkg::ADDR_IN_READBACK: begin
				rimage = as_byte(readback);
			end
			fbp_pkg::ADDR_DIR_CTRL: begin
				rimage = as_byte(dir_q);
			end
			fbp_pkg::ADDR_PULLUP_EN: begin
				rimage = as_byte(pullup_q);
			end
			fbp_pkg::ADDR_OSC_FUNC: begin
				rimage = as_byte(osc_q);
			end
			default: begin
				rimage = 8'h00;
			end
		endcase
	end

	// Read data stand only in the cycle after the strobe and are 0 at
	// all other times, so a stray sample never shows stale contents.
	always_comb begin
		rdata_d = 8'h00;
		if (req.rd && !sel_none) begin
			rdata_d = rimage;
		end
	end

	// A single flop lies between pins and bus: the readback is one
	// sample of the pin levels, taken at the read strobe.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			rdata_q <= 8'h00;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	// Pad controls come from the pin module; rdata and the reset request
	// come straight from flops here.
	assign rdata = rdata_q;
	assign pin_out = pad.out_val;
	assign pin_oe = pad.out_en;
	assign pin_pullup = pad.pullup_en;
	assign sysclk_reset = sysclk_reset_q;
endmodule // fbp_port
